// *** src/tic_pkg.sv ***
// terminal i/o conditioning package: constants, codes and config structs
// Operation
// - Output terminals 11 to 15 and the relay output each have own on and off delays of 0.0 to 100.0 s, default 0.0.
// - Six logic output signals each take two independently selected sources, selection codes defaulting to 00.
// - A logic output signal may not select any of the six logic output signals as a source.
// - Each logic output signal combines its sources with 00 AND, 01 OR, 02 XOR, default AND.
// - Eight multi-function inputs and the forward-run input each have a response time of 0 to 200 x 2 ms, default 1.
package tic_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int RESP_UNIT_US = 2000;
  localparam int DLY_UNIT_MS = 100;
  localparam int RESP_TICK_CYCLES = CLK_HZ / 1_000_000 * RESP_UNIT_US;
  localparam int DLY_TICK_CYCLES = CLK_HZ / 1000 * DLY_UNIT_MS;

  localparam int N_IN = 9;
  localparam int FWD_IDX = 8;
  localparam int N_LOGIC = 6;
  localparam int N_DLY = 6;
  localparam int RELAY_IDX = 5;

  localparam int RESP_W = 8;
  localparam logic [RESP_W-1:0] RESP_MAX = 8'hC8;
  localparam logic [RESP_W-1:0] RESP_RST = 8'h01;

  localparam int DLY_W = 10;
  localparam logic [DLY_W-1:0] DLY_MAX = 10'h3E8;
  localparam logic [DLY_W-1:0] DLY_RST = 10'h000;

  localparam int SEL_W = 7;
  localparam logic [SEL_W-1:0] SEL_RST = 7'h00;

  typedef enum logic [1:0] {
    TIC_OP_AND = 2'h0,
    TIC_OP_OR = 2'h1,
    TIC_OP_XOR = 2'h2
  } tic_op_t;

  typedef struct packed {
    logic [SEL_W-1:0] sel1;
    logic [SEL_W-1:0] sel2;
    logic [1:0] op;
  } tic_logic_cfg_t;

  typedef struct packed {
    logic [DLY_W-1:0] on_dly;
    logic [DLY_W-1:0] off_dly;
  } tic_dly_cfg_t;
endpackage : tic_pkg

// *** src/tic_top.sv ***
// terminal i/o conditioning: input filters, combined logic outputs, output delays
`timescale 1ns/1ps
module tic_top #(
  parameter int RESP_TICK = tic_pkg::RESP_TICK_CYCLES,
  parameter int DLY_TICK = tic_pkg::DLY_TICK_CYCLES,
  parameter int N_SRC = 64,
  parameter int LOGIC_CODE_FIRST = 33
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [tic_pkg::N_IN-1:0] in_raw,
  input wire logic [tic_pkg::N_IN-1:0][tic_pkg::RESP_W-1:0] resp_time,
  input wire logic [N_SRC-1:0] func_src,
  input wire tic_pkg::tic_logic_cfg_t [tic_pkg::N_LOGIC-1:0] logic_cfg,
  input wire logic [tic_pkg::N_DLY-1:0] dly_src,
  input wire tic_pkg::tic_dly_cfg_t [tic_pkg::N_DLY-1:0] dly_cfg,
  output logic [tic_pkg::N_IN-1:0] in_filt_ff,
  output logic [tic_pkg::N_LOGIC-1:0] combined_logic_outputs_ff,
  output logic [tic_pkg::N_DLY-1:0] term_out_ff
);
  import tic_pkg::*;

  localparam int RT_W = $clog2(RESP_TICK + 1);
  localparam int DT_W = $clog2(DLY_TICK + 1);

  logic [RT_W-1:0] resp_div_ff;
  logic [DT_W-1:0] dly_div_ff;
  logic resp_tick_ff;
  logic dly_tick_ff;

  // 2 ms time base for the input filters
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      resp_div_ff <= '0;
      resp_tick_ff <= 1'b0;
    end
    else if (resp_div_ff == RT_W'(RESP_TICK - 1))
    begin
      resp_div_ff <= '0;
      resp_tick_ff <= 1'b1;
    end
    else
    begin
      resp_div_ff <= resp_div_ff + RT_W'(1);
      resp_tick_ff <= 1'b0;
    end
  end

  // 0.1 s time base for the output delays
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      dly_div_ff <= '0;
      dly_tick_ff <= 1'b0;
    end
    else if (dly_div_ff == DT_W'(DLY_TICK - 1))
    begin
      dly_div_ff <= '0;
      dly_tick_ff <= 1'b1;
    end
    else
    begin
      dly_div_ff <= dly_div_ff + DT_W'(1);
      dly_tick_ff <= 1'b0;
    end
  end

  // input response filters
  genvar gi;
  generate
    for (gi = 0; gi < N_IN; gi++)
    begin : g_in
      logic [RESP_W-1:0] cnt_ff;
      logic [RESP_W-1:0] lim;
      logic differ;

      // settings above the range act as the top of the range
      always_comb
      begin
        if (resp_time[gi] > RESP_MAX)
        begin
          lim = RESP_MAX;
        end
        else
        begin
          lim = resp_time[gi];
        end
      end
      assign differ = in_raw[gi] != in_filt_ff[gi];

      always_ff @(posedge clk)
      begin
        if (sys_rst)
        begin
          cnt_ff <= '0;
          in_filt_ff[gi] <= 1'b0;
        end
        else if (!differ)
        begin
          cnt_ff <= '0;
        end
        else if (cnt_ff >= lim)
        begin
          in_filt_ff[gi] <= in_raw[gi];
          cnt_ff <= '0;
        end
        else if (resp_tick_ff)
        begin
          cnt_ff <= cnt_ff + RESP_W'(1);
        end
      end
    end
  endgenerate

  function automatic logic pick_src(input logic [SEL_W-1:0] sel, input logic [N_SRC-1:0] src);
    int idx;
    idx = int'(sel);
    pick_src = 1'b0;
    // codes of the combined outputs themselves are refused and read as inactive
    if (idx >= LOGIC_CODE_FIRST && idx < LOGIC_CODE_FIRST + N_LOGIC)
    begin
      pick_src = 1'b0;
    end
    else if (idx < N_SRC)
    begin
      pick_src = src[idx];
    end
  endfunction : pick_src

  // combined logic outputs
  genvar gl;
  generate
    for (gl = 0; gl < N_LOGIC; gl++)
    begin : g_log
      logic a;
      logic b;
      logic nxt_val;

      assign a = pick_src(logic_cfg[gl].sel1, func_src);
      assign b = pick_src(logic_cfg[gl].sel2, func_src);

      always_comb
      begin
        unique case (logic_cfg[gl].op)
          TIC_OP_AND: nxt_val = a & b;
          TIC_OP_OR: nxt_val = a | b;
          TIC_OP_XOR: nxt_val = a ^ b;
          default: nxt_val = 1'b0;
        endcase
      end

      always_ff @(posedge clk)
      begin
        if (sys_rst)
        begin
          combined_logic_outputs_ff[gl] <= 1'b0;
        end
        else
        begin
          combined_logic_outputs_ff[gl] <= nxt_val;
        end
      end
    end
  endgenerate

  // on and off delays of output terminals 11 to 15 and the relay
  genvar gd;
  generate
    for (gd = 0; gd < N_DLY; gd++)
    begin : g_dly
      logic [DLY_W-1:0] cnt_ff;
      logic [DLY_W-1:0] sel_dly;
      logic [DLY_W-1:0] lim;
      logic differ;

      // the delay is chosen by the level the output is heading for
      always_comb
      begin
        if (dly_src[gd])
        begin
          sel_dly = dly_cfg[gd].on_dly;
        end
        else
        begin
          sel_dly = dly_cfg[gd].off_dly;
        end
      end

      // settings above the range act as the top of the range
      always_comb
      begin
        if (sel_dly > DLY_MAX)
        begin
          lim = DLY_MAX;
        end
        else
        begin
          lim = sel_dly;
        end
      end
      assign differ = dly_src[gd] != term_out_ff[gd];

      always_ff @(posedge clk)
      begin
        if (sys_rst)
        begin
          cnt_ff <= '0;
          term_out_ff[gd] <= 1'b0;
        end
        else if (!differ)
        begin
          cnt_ff <= '0;
        end
        else if (cnt_ff >= lim)
        begin
          term_out_ff[gd] <= dly_src[gd];
          cnt_ff <= '0;
        end
        else if (dly_tick_ff)
        begin
          cnt_ff <= cnt_ff + DLY_W'(1);
        end
      end
    end
  endgenerate
endmodule : tic_top

// *** sim/tic_field.sv ***
// field wiring model: switch contacts feeding the raw input terminals
`timescale 1ns/1ps
module tic_field (
  input wire logic clk,
  input wire logic [tic_pkg::N_IN-1:0] sw,
  output logic [tic_pkg::N_IN-1:0] in_raw = '0
);
  import tic_pkg::*;
  always @(posedge clk)
    in_raw <= sw;
endmodule : tic_field

// *** sim/tic_top_chk.sv ***
// port checker for terminal i/o conditioning
`timescale 1ns/1ps
module tic_chk #(
  parameter int RESP_TICK = 10,
  parameter int DLY_TICK = 20,
  parameter int N_SRC = 64,
  parameter int LOGIC_CODE_FIRST = 33
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [tic_pkg::N_IN-1:0] in_raw,
  input wire logic [tic_pkg::N_IN-1:0][tic_pkg::RESP_W-1:0] resp_time,
  input wire logic [N_SRC-1:0] func_src,
  input wire tic_pkg::tic_logic_cfg_t [tic_pkg::N_LOGIC-1:0] logic_cfg,
  input wire logic [tic_pkg::N_DLY-1:0] dly_src,
  input wire tic_pkg::tic_dly_cfg_t [tic_pkg::N_DLY-1:0] dly_cfg,
  input wire logic [tic_pkg::N_IN-1:0] in_filt_ff,
  input wire logic [tic_pkg::N_LOGIC-1:0] combined_logic_outputs_ff,
  input wire logic [tic_pkg::N_DLY-1:0] term_out_ff
);
  import tic_pkg::*;
  tic_logic_cfg_t c;
  logic a, b, ok, lo;
  assign c = logic_cfg[0];
  assign a = func_src[c.sel1[5:0]];
  assign b = func_src[c.sel2[5:0]];
  assign ok = c.sel1 < LOGIC_CODE_FIRST && c.sel2 < LOGIC_CODE_FIRST;
  assign lo = combined_logic_outputs_ff[0];
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  chk_op_and: assert property (!$past(sys_rst) && ok && c.op == 2'h0 |=> lo == $past(a & b))
    else $error("and output wrong");
  chk_op_or: assert property (!$past(sys_rst) && ok && c.op == 2'h1 |=> lo == $past(a | b))
    else $error("or output wrong");
  chk_op_xor: assert property (!$past(sys_rst) && ok && c.op == 2'h2 |=> lo == $past(a ^ b))
    else $error("xor output wrong");
  chk_self_sel: assert property (!$past(sys_rst) && c.sel1 >= LOGIC_CODE_FIRST && c.sel1 < LOGIC_CODE_FIRST + 6
    && c.op == 2'h0 |=> !lo)
    else $error("logic output used as source");
  chk_in_zero: assert property (!$past(sys_rst) && resp_time[0] == 8'h00 && in_raw[0] != in_filt_ff[0]
    |=> in_filt_ff[0] == $past(in_raw[0]))
    else $error("zero response time late");
  chk_in_source: assert property ($changed(in_filt_ff[0]) |-> in_filt_ff[0] == $past(in_raw[0]))
    else $error("input changed to stale level");
  chk_out_source: assert property ($changed(term_out_ff[0]) |-> term_out_ff[0] == $past(dly_src[0]))
    else $error("output changed to stale level");
  cov_in: cover property ($rose(in_filt_ff[0]));
  cov_out: cover property ($rose(term_out_ff[0]));
  cov_lo: cover property ($rose(lo));
endmodule : tic_chk
bind tic_top tic_chk #(.RESP_TICK(RESP_TICK), .DLY_TICK(DLY_TICK), .N_SRC(N_SRC), .LOGIC_CODE_FIRST(LOGIC_CODE_FIRST))
  i_chk (.clk, .sys_rst, .in_raw, .resp_time, .func_src, .logic_cfg, .dly_src, .dly_cfg, .in_filt_ff,
  .combined_logic_outputs_ff, .term_out_ff);

// *** sim/tb_terminal_io_conditioning.sv ***
// testbench for terminal i/o conditioning
`timescale 1ns/1ps
module tb_terminal_io_conditioning;
  import tic_pkg::*;
  logic clk = 0;
  logic sys_rst = 1;
  logic [N_IN-1:0] sw = '0;
  logic [N_IN-1:0] in_raw, in_filt;
  logic [N_IN-1:0][RESP_W-1:0] resp = '0;
  logic [63:0] src = '0;
  tic_logic_cfg_t [N_LOGIC-1:0] lcfg = '0;
  logic [N_DLY-1:0] dsrc = '0;
  logic [N_DLY-1:0] tout, lout;
  tic_dly_cfg_t [N_DLY-1:0] dcfg = '0;
  int err_count = 0;
  int cmp_count = 0;
  tic_field i_fld (.clk, .sw, .in_raw);
  tic_top #(.RESP_TICK(10), .DLY_TICK(20)) i_dut (.clk, .sys_rst, .in_raw, .resp_time(resp), .func_src(src),
    .logic_cfg(lcfg), .dly_src(dsrc), .dly_cfg(dcfg), .in_filt_ff(in_filt), .combined_logic_outputs_ff(lout),
    .term_out_ff(tout));
  initial
    forever #10 clk = ~clk;
  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic check(string name, logic [8:0] seen, logic [8:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic summarize();
    $display("checks %0d errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize
  task automatic t_logic();
    src[0] = 1;
    cyc(2);
    check("deflt", lout[0], 1);
    for (int i = 0; i < 16; i++)
    begin
      lcfg[0] = {7'h02, 7'h03, i[3:2]};
      src[3:2] = i[1:0];
      cyc(2);
      check("op", lout[0], 9'(16'h06E8 >> i & 1));
    end
    lcfg[0] = {7'h21, 7'h00, 2'h0};
    src[33] = 1;
    cyc(2);
    check("self", lout[0], 0);
  endtask : t_logic
  task automatic t_in();
    resp[0] = 8'h02;
    sw[0] = 1;
    cyc(5);
    sw[0] = 0;
    cyc(30);
    check("glitch", in_filt[0], 0);
    sw[0] = 1;
    cyc(9);
    check("early", in_filt[0], 0);
    cyc(20);
    check("late", in_filt[0], 1);
    resp[0] = 8'h00;
    resp[8] = 8'h00;
    sw = 9'h100;
    cyc(3);
    check("zero", in_filt, 9'h100);
  endtask : t_in
  task automatic t_dly();
    dcfg[0] = {10'h002, 10'h000};
    dsrc = 6'h21;
    cyc(2);
    check("relay", tout, 6'h20);
    cyc(15);
    check("early", tout, 6'h20);
    cyc(30);
    check("late", tout, 6'h21);
    dsrc = 6'h00;
    cyc(2);
    check("off", tout, 6'h00);
  endtask : t_dly
  initial
  begin
    #20us;
    err_count++;
    summarize();
  end
  initial
  begin
    cyc(5);
    sys_rst = 0;
    t_logic();
    t_in();
    t_dly();
    summarize();
  end
endmodule : tb_terminal_io_conditioning
